// >>> design/cam_map.svh
`ifndef CAM_MAP_SVH
`define CAM_MAP_SVH
// tile geometry
`define CAM_WORDS     32
`define CAM_WIDTH     32
`define CAM_AW        5
`define CAM_OUT_W     16
// write sequence lengths in clock cycles
`define CAM_WR_CYC    2
`define CAM_WR_CYC_DC 3
// controller register byte offsets
`define CAM_REG_CTRL  8'h00
`define CAM_REG_KEY   8'h04
`define CAM_REG_WDATA 8'h08
`define CAM_REG_WMASK 8'h0C
`define CAM_REG_WADDR 8'h10
`define CAM_REG_STAT  8'h14
`define CAM_REG_RES   8'h18
`define CAM_REG_HITLO 8'h1C
`define CAM_REG_HITHI 8'h20
`define CAM_REG_ISTAT 8'h24
`define CAM_REG_IMASK 8'h28
// control field positions and reset value
`define CAM_CTRL_ENC  0
`define CAM_CTRL_IENA 1
`define CAM_CTRL_OENA 2
`define CAM_CTRL_ICLR 3
`define CAM_CTRL_OCLR 4
`define CAM_CTRL_RST  5'h07
// interrupt event bits
`define CAM_EV_WDONE  0
`define CAM_EV_SDONE  1
`define CAM_EV_HIT    2
`define CAM_EV_W      3
`endif

// >>> design/cam_pkg.sv
package cam_pkg;
  typedef logic [31:0] cam_word_t;
  typedef logic [4:0]  cam_addr_t;
  typedef logic [15:0] cam_half_t;
  // tile write sequencer
  typedef enum logic [1:0] {
    CAM_WS_IDLE = 2'b00,
    CAM_WS_DATA = 2'b01,
    CAM_WS_CARE = 2'b10
  } cam_wstate_e;
  // controller sequencer
  typedef enum logic [1:0] {
    CAM_CS_IDLE = 2'b00,
    CAM_CS_WR   = 2'b01,
    CAM_CS_WAIT = 2'b10,
    CAM_CS_SRCH = 2'b11
  } cam_cstate_e;
endpackage : cam_pkg

// >>> design/cam_if.sv
`timescale 1ns/1ps
interface cam_if;
  import cam_pkg::*;
  logic      in_clk;
  logic      out_clk;
  logic      in_ena;
  logic      out_ena;
  logic      in_clr;
  logic      out_clr;
  logic      store_gate;
  cam_addr_t wr_addr;
  cam_word_t wr_data;
  cam_word_t wr_mask;
  logic      fetch_gate;
  cam_word_t key;
  logic      enc_mode;
  logic      busy;
  logic      match;
  cam_half_t q;
  logic      q_half;
  logic      q_valid;
  modport tile (input in_clk, out_clk, in_ena, out_ena, in_clr, out_clr, store_gate, wr_addr, wr_data,
                wr_mask, fetch_gate, key, enc_mode, output busy, match, q, q_half, q_valid);
  modport user (output in_clk, out_clk, in_ena, out_ena, in_clr, out_clr, store_gate, wr_addr, wr_data,
                wr_mask, fetch_gate, key, enc_mode, input busy, match, q, q_half, q_valid);
endinterface : cam_if

// >>> design/cam_tile.sv
`timescale 1ns/1ps
`include "cam_map.svh"
// What this block does
// - search every entry in parallel, report location
// - match high when any entry matches
// - thirty-two entries of thirty-two bits
// - don't-care bits ignored in comparison
// - encoded mode outputs matching entry index
// - unencoded mode: two halves on sixteen lines
// - unencoded raises every matching entry line
// - user avoids duplicates when using encoded output
// - write takes two cycles, request held
// - don't-care write takes a third cycle
// - initial contents loadable, writable at run
// - each path has its own optional register
// - input and output registers separately clocked
// - user logic drives gates, clocks, enables, clears
// - all registers asynchronously clearable
module cam_tile #(
  parameter int                              WORDS      = `CAM_WORDS,
  parameter int                              WIDTH      = `CAM_WIDTH,
  parameter bit                              REG_DIN    = 1'b1,
  parameter bit                              REG_DOUT   = 1'b1,
  parameter bit                              REG_RADDR  = 1'b1,
  parameter bit                              REG_WADDR  = 1'b1,
  parameter bit                              REG_WE     = 1'b1,
  parameter bit                              REG_RE     = 1'b1,
  parameter logic [`CAM_WORDS*`CAM_WIDTH-1:0] INIT_DATA  = '0,
  parameter logic [`CAM_WORDS-1:0]           INIT_VALID = '0
) (
  // chip-wide reset, clears every register at once
  input  wire logic rst_i,
  // user side of the tile
  cam_if.tile       cam
);
  import cam_pkg::*;

  // ****************************************
  // clears and clock domains
  // ****************************************
  // async clears
  wire logic in_clr_w  = cam.in_clr | rst_i;
  wire logic out_clr_w = cam.out_clr | rst_i;

  // ****************************************
  // optional path registers
  // ****************************************
  cam_word_t wd_q;
  cam_word_t wm_q;
  cam_addr_t wa_q;
  cam_word_t key_q;
  logic      we_q;
  logic      re_q;

  generate
    if (REG_DIN) begin : g_din
      always_ff @(posedge cam.in_clk or posedge in_clr_w) begin
        if (in_clr_w) begin
          wd_q <= 32'h0;
          wm_q <= 32'h0;
        end else if (cam.in_ena) begin
          wd_q <= cam.wr_data;
          wm_q <= cam.wr_mask;
        end
      end
    end else begin : g_din_n
      assign wd_q = cam.wr_data;
      assign wm_q = cam.wr_mask;
    end
    if (REG_WADDR) begin : g_wa
      always_ff @(posedge cam.in_clk or posedge in_clr_w) begin
        if (in_clr_w) wa_q <= 5'h0;
        else if (cam.in_ena) wa_q <= cam.wr_addr;
      end
    end else begin : g_wa_n
      assign wa_q = cam.wr_addr;
    end
    if (REG_RADDR) begin : g_key
      always_ff @(posedge cam.in_clk or posedge in_clr_w) begin
        if (in_clr_w) key_q <= 32'h0;
        else if (cam.in_ena) key_q <= cam.key;
      end
    end else begin : g_key_n
      assign key_q = cam.key;
    end
    if (REG_WE) begin : g_we
      always_ff @(posedge cam.in_clk or posedge in_clr_w) begin
        if (in_clr_w) we_q <= 1'b0;
        else if (cam.in_ena) we_q <= cam.store_gate;
      end
    end else begin : g_we_n
      assign we_q = cam.store_gate;
    end
    if (REG_RE) begin : g_re
      always_ff @(posedge cam.in_clk or posedge in_clr_w) begin
        if (in_clr_w) re_q <= 1'b0;
        else if (cam.in_ena) re_q <= cam.fetch_gate;
      end
    end else begin : g_re_n
      assign re_q = cam.fetch_gate;
    end
  endgenerate

  // ****************************************
  // storage and write sequence
  // ****************************************
  // storage array
  cam_word_t   data_r  [WORDS];
  cam_word_t   care_r  [WORDS];
  logic [WORDS-1:0] valid_r;
  cam_wstate_e ws_r;
  logic        we_prev_r;
  cam_addr_t   wa_r;
  cam_word_t   wd_r;
  cam_word_t   wm_r;

  // a held request must start only one write, so start on its rising edge
  wire logic wr_start = we_q & ~we_prev_r & (ws_r == CAM_WS_IDLE);
  wire logic wr_dc    = |wm_r;

  // two-cycle write, third for care, preload
  always_ff @(posedge cam.in_clk or posedge in_clr_w) begin
    if (in_clr_w) begin
      ws_r      <= CAM_WS_IDLE;
      we_prev_r <= 1'b0;
      wa_r      <= 5'h0;
      wd_r      <= 32'h0;
      wm_r      <= 32'h0;
      valid_r   <= INIT_VALID;
      for (int i = 0; i < WORDS; i++) begin
        data_r[i] <= INIT_DATA[i*WIDTH +: WIDTH];
        care_r[i] <= 32'hFFFFFFFF;
      end
    end else if (cam.in_ena) begin
      we_prev_r <= we_q;
      case (ws_r)
        CAM_WS_IDLE: begin
          if (wr_start) begin
            wa_r <= wa_q;
            wd_r <= wd_q;
            wm_r <= wm_q;
            ws_r <= CAM_WS_DATA;
          end
        end
        CAM_WS_DATA: begin
          data_r[wa_r]  <= wd_r;
          care_r[wa_r]  <= 32'hFFFFFFFF;
          valid_r[wa_r] <= 1'b1;
          ws_r          <= wr_dc ? CAM_WS_CARE : CAM_WS_IDLE;
        end
        CAM_WS_CARE: begin
          care_r[wa_r] <= ~wm_r;
          ws_r         <= CAM_WS_IDLE;
        end
        default: ws_r <= CAM_WS_IDLE;
      endcase
    end
  end

  assign cam.busy = (ws_r != CAM_WS_IDLE);

  // ****************************************
  // parallel compare and encoder
  // ****************************************
  logic [WORDS-1:0] hit;

  // parallel compare, don't-care masked, empty entries never hit
  generate
    for (genvar g = 0; g < WORDS; g++) begin : g_cmp
      assign hit[g] = valid_r[g] & (((data_r[g] ^ key_q) & care_r[g]) == 32'h0);
    end
  endgenerate

  wire logic any_hit = |hit;

  // lowest index wins; with duplicates the index is not meaningful
  cam_addr_t enc_idx;
  always_comb begin
    enc_idx = 5'h0;
    for (int i = WORDS - 1; i >= 0; i--) begin
      if (hit[i]) enc_idx = i[4:0];
    end
  end

  // ****************************************
  // output stage
  // ****************************************
  cam_half_t hi_r;
  logic      hi_pend_r;

  // first half now, second half next cycle; all lines raised
  wire cam_half_t lo_half = hit[15:0];
  wire cam_half_t hi_half = hit[31:16];
  wire logic      fetch_w = re_q & cam.in_ena;

  wire cam_half_t q_nxt     = fetch_w ? (cam.enc_mode ? {11'h0, enc_idx} : lo_half)
                                      : (hi_pend_r ? hi_r : 16'h0);
  wire logic      match_nxt = fetch_w ? any_hit : cam.match;
  wire logic      half_nxt  = ~fetch_w & hi_pend_r;
  wire logic      valid_nxt = fetch_w | hi_pend_r;

  always_ff @(posedge cam.out_clk or posedge out_clr_w) begin
    if (out_clr_w) begin
      hi_r      <= 16'h0;
      hi_pend_r <= 1'b0;
    end else if (cam.out_ena) begin
      hi_r      <= hi_half;
      hi_pend_r <= fetch_w & ~cam.enc_mode;
    end
  end

  generate
    if (REG_DOUT) begin : g_dout
      logic      match_r;
      cam_half_t q_r;
      logic      half_r;
      logic      valid_r2;
      always_ff @(posedge cam.out_clk or posedge out_clr_w) begin
        if (out_clr_w) begin
          match_r  <= 1'b0;
          q_r      <= 16'h0;
          half_r   <= 1'b0;
          valid_r2 <= 1'b0;
        end else if (cam.out_ena) begin
          match_r  <= match_nxt;
          q_r      <= q_nxt;
          half_r   <= half_nxt;
          valid_r2 <= valid_nxt;
        end
      end
      assign cam.match   = match_r;
      assign cam.q       = q_r;
      assign cam.q_half  = half_r;
      assign cam.q_valid = valid_r2;
    end else begin : g_dout_n
      // unregistered: flag follows the live compare
      assign cam.match   = any_hit;
      assign cam.q       = q_nxt;
      assign cam.q_half  = half_nxt;
      assign cam.q_valid = valid_nxt;
    end
  endgenerate
endmodule : cam_tile

// >>> design/cam_user.sv
`timescale 1ns/1ps
`include "cam_map.svh"
module cam_user (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // wishbone slave
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [7:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  // interrupt
  output logic             irq_o,
  // tile side
  cam_if.user              cam
);
  import cam_pkg::*;

  // ****************************************
  // bus decode
  // ****************************************
  logic [4:0]  ctrl_r;
  cam_word_t   key_r;
  cam_word_t   wdata_r;
  cam_word_t   wmask_r;
  cam_addr_t   waddr_r;
  logic [2:0]  ist_r;
  logic [2:0]  imask_r;
  cam_addr_t   res_r;
  logic        match_r;
  cam_half_t   hitlo_r;
  cam_half_t   hithi_r;
  cam_cstate_e cs_r;
  logic [1:0]  cnt_r;
  logic        ack_r;
  logic [31:0] dat_r;

  wire logic        acc  = cyc_i & stb_i & ack_r;
  wire logic        wr   = acc & we_i & (&sel_i);
  wire logic        idle = (cs_r == CAM_CS_IDLE);
  wire logic        go_w = wr & (adr_i == `CAM_REG_WADDR) & idle;
  wire logic        go_s = wr & (adr_i == `CAM_REG_KEY) & idle;
  wire logic [31:0] stat = {29'h0, match_r, ~idle, cam.busy};
  logic [31:0] rd_mux;
  always_comb begin
    case (adr_i)
      `CAM_REG_CTRL:  rd_mux = {27'h0, ctrl_r};
      `CAM_REG_KEY:   rd_mux = key_r;
      `CAM_REG_WDATA: rd_mux = wdata_r;
      `CAM_REG_WMASK: rd_mux = wmask_r;
      `CAM_REG_WADDR: rd_mux = {27'h0, waddr_r};
      `CAM_REG_STAT:  rd_mux = stat;
      `CAM_REG_RES:   rd_mux = {27'h0, res_r};
      `CAM_REG_HITLO: rd_mux = {16'h0, hitlo_r};
      `CAM_REG_HITHI: rd_mux = {16'h0, hithi_r};
      `CAM_REG_ISTAT: rd_mux = {29'h0, ist_r};
      `CAM_REG_IMASK: rd_mux = {29'h0, imask_r};
      default:        rd_mux = 32'h0;
    endcase
  end

  // answer one cycle after the request, drop the cycle after
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
      dat_r <= 32'h0;
    end else begin
      ack_r <= cyc_i & stb_i & ~ack_r;
      dat_r <= rd_mux;
    end
  end
  assign ack_o = ack_r;
  assign dat_o = dat_r;

  // ****************************************
  // tile drive
  // ****************************************
  // clocks, enables and clears come from this logic
  assign cam.in_clk   = clk_i;
  assign cam.out_clk  = clk_i;
  assign cam.enc_mode = ctrl_r[`CAM_CTRL_ENC];
  assign cam.in_ena   = ctrl_r[`CAM_CTRL_IENA];
  assign cam.out_ena  = ctrl_r[`CAM_CTRL_OENA];
  assign cam.in_clr   = ctrl_r[`CAM_CTRL_ICLR];
  assign cam.out_clr  = ctrl_r[`CAM_CTRL_OCLR];
  // the search word must reach the tile on the same edge as the fetch pulse;
  // key_r only updates on that edge, so the bus word is passed straight through
  assign cam.key      = go_s ? dat_i : key_r;
  assign cam.wr_addr  = waddr_r;
  assign cam.wr_data  = wdata_r;
  assign cam.wr_mask  = wmask_r;
  assign cam.store_gate = (cs_r == CAM_CS_WR);
  assign cam.fetch_gate = go_s;

  // hold two cycles, three with don't-cares
  wire logic [1:0] hold = (|wmask_r) ? 2'(`CAM_WR_CYC_DC - 1) : 2'(`CAM_WR_CYC - 1);
  wire logic       got  = (cs_r == CAM_CS_SRCH) & cam.q_valid;
  wire logic       fin  = got & (cam.enc_mode | cam.q_half);
  // the tile flag holds through both halves, so it is current at fin; match_r may be stale
  wire logic [2:0] ev   = {fin & cam.match, fin, (cs_r == CAM_CS_WAIT) & ~cam.busy};

  // ****************************************
  // registers and sequencer
  // ****************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_r  <= `CAM_CTRL_RST;
      key_r   <= 32'h0;
      wdata_r <= 32'h0;
      wmask_r <= 32'h0;
      waddr_r <= 5'h0;
      imask_r <= 3'h0;
      ist_r   <= 3'h0;
      res_r   <= 5'h0;
      match_r <= 1'b0;
      hitlo_r <= 16'h0;
      hithi_r <= 16'h0;
      cs_r    <= CAM_CS_IDLE;
      cnt_r   <= 2'h0;
    end else begin
      if (wr & (adr_i == `CAM_REG_CTRL)) ctrl_r <= dat_i[4:0];
      if (go_s) key_r <= dat_i;
      if (wr & (adr_i == `CAM_REG_WDATA) & idle) wdata_r <= dat_i;
      if (wr & (adr_i == `CAM_REG_WMASK) & idle) wmask_r <= dat_i;
      if (go_w) waddr_r <= dat_i[4:0];
      if (wr & (adr_i == `CAM_REG_IMASK)) imask_r <= dat_i[2:0];
      // event set wins over a write-one clear
      ist_r <= (ist_r & ~((wr & (adr_i == `CAM_REG_ISTAT)) ? dat_i[2:0] : 3'h0)) | ev;
      case (cs_r)
        CAM_CS_IDLE: begin
          cnt_r <= 2'h0;
          if (go_w) cs_r <= CAM_CS_WR;
          else if (go_s) cs_r <= CAM_CS_SRCH;
        end
        CAM_CS_WR: begin
          cnt_r <= cnt_r + 2'h1;
          if (cnt_r == hold) cs_r <= CAM_CS_WAIT;
        end
        CAM_CS_WAIT: begin
          if (~cam.busy) cs_r <= CAM_CS_IDLE;
        end
        CAM_CS_SRCH: begin
          if (got & ~cam.q_half) begin
            match_r <= cam.match;
            res_r   <= cam.q[4:0];
            hitlo_r <= cam.q;
          end
          if (got & cam.q_half) hithi_r <= cam.q;
          if (fin) cs_r <= CAM_CS_IDLE;
        end
        default: cs_r <= CAM_CS_IDLE;
      endcase
    end
  end

  assign irq_o = |(ist_r & imask_r);
endmodule : cam_user

// >>> verification/cam_props.sv
`timescale 1ns/1ps
// ************************************
// search tile handshake checker
// ************************************
module cam_props
  import cam_pkg::*;
(
  // clock and reset
  input logic      in_clk,
  input logic      rst_i,
  // requests toward the tile
  input logic      store_gate,
  input cam_word_t wr_mask,
  input logic      fetch_gate,
  input logic      enc_mode,
  // tile answers
  input logic      busy,
  input logic      match,
  input cam_half_t q,
  input logic      q_half,
  input logic      q_valid
);
  default clocking cb @(posedge in_clk); endclocking
  default disable iff (rst_i);

  // encoded search answers once, two cycles after the pulse
  a_enc_answer:
    assert property (fetch_gate && enc_mode |-> ##2 (q_valid && !q_half) ##1 !q_valid)
    else $error("encoded search answer late or repeated");
  a_unenc_halves:
    assert property (fetch_gate && !enc_mode |-> ##2 (q_valid && !q_half) ##1 (q_valid && q_half) ##1 !q_valid)
    else $error("hit lines not sent as low then high half");
  a_miss_quiet:
    assert property (q_valid && !match |-> q == '0)
    else $error("output not zero on a miss");
  a_hit_flag:
    assert property (q_valid && !enc_mode && q != '0 |-> match)
    else $error("hit line up without match flag");
  a_enc_range:
    assert property (q_valid && enc_mode |-> q[15:5] == '0)
    else $error("encoded index beyond thirty-two entries");
  a_write_plain:
    assert property ($rose(store_gate) && wr_mask == '0 |-> ##2 busy ##1 !busy)
    else $error("plain write not two cycles");
  a_write_care:
    assert property ($rose(store_gate) && wr_mask != '0 |-> ##2 busy [*2] ##1 !busy)
    else $error("masked write not three cycles");
  // the clear is asynchronous, so outputs are already low at the next edge
  a_clear_all:
    assert property (disable iff (1'b0) rst_i |-> !busy && !match && !q_valid && q == '0)
    else $error("tile outputs not cleared by reset");
endmodule : cam_props

// >>> verification/testbench.sv
`timescale 1ns/1ps
`include "cam_map.svh"
// ************************************
// controller plus tile bench
// ************************************
module testbench;
  import cam_pkg::*;
  logic        clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, irq_o;
  logic [7:0]  adr_i;
  logic [3:0]  sel_i;
  logic [31:0] dat_i, dat_o, rv;
  int          mismatches, checks_done;

  cam_if cam_bus ();
  // entry 31 preloaded so configuration contents can be seen
  cam_tile #(.INIT_DATA({32'h5EED0031, 992'h0}), .INIT_VALID(32'h80000000)) cam_tile_inst (
    .rst_i(rst_i), .cam(cam_bus));
  cam_user cam_user_inst (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .irq_o(irq_o), .cam(cam_bus));
  cam_props cam_props_inst (.in_clk(cam_bus.in_clk), .rst_i(rst_i), .store_gate(cam_bus.store_gate),
    .wr_mask(cam_bus.wr_mask), .fetch_gate(cam_bus.fetch_gate), .enc_mode(cam_bus.enc_mode),
    .busy(cam_bus.busy), .match(cam_bus.match), .q(cam_bus.q), .q_half(cam_bus.q_half),
    .q_valid(cam_bus.q_valid));

  task complete_run;
    $display("counts: %0d checks, %0d mismatches", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : complete_run

  task hang(input string what);
    mismatches++;
    $display("unexpected at %0t: %s", $time, what);
    complete_run();
  endtask : hang

  task chk32(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask : chk32

  task chk1(input logic got, input logic exp, input string what);
    chk32({31'h0, got}, {31'h0, exp}, what);
  endtask : chk1

  // one classic cycle; the master holds everything until ack is sampled
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    int n;
    n = 0;
    cyc_i <= 1'b1; stb_i <= 1'b1; we_i <= w; adr_i <= a; dat_i <= d; sel_i <= 4'hF;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 50);
    r = dat_o;
    if (ack_o !== 1'b1) hang("no bus answer");
    cyc_i <= 1'b0; stb_i <= 1'b0; we_i <= 1'b0;
    @(posedge clk_i);
  endtask : wb

  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    wb(1'b1, a, d, x);
  endtask : wr

  task rd(input logic [7:0] a);
    wb(1'b0, a, 32'h0, rv);
  endtask : rd

  // poll the controller busy bit, bounded
  task wait_idle;
    int n;
    n = 0;
    do begin
      rd(`CAM_REG_STAT);
      n++;
    end while (rv[1] !== 1'b0 && n < 40);
    if (rv[1] !== 1'b0) hang("controller stuck busy");
  endtask : wait_idle

  task put(input logic [4:0] a, input logic [31:0] d, input logic [31:0] m);
    wr(`CAM_REG_WDATA, d);
    wr(`CAM_REG_WMASK, m);
    wr(`CAM_REG_WADDR, {27'h0, a});
    wait_idle();
  endtask : put

  task find(input logic [31:0] k);
    wr(`CAM_REG_KEY, k);
    wait_idle();
  endtask : find

  // reset values, unmapped place and the preloaded entry
  task t_reset;
    rd(`CAM_REG_CTRL); chk32(rv, {27'h0, `CAM_CTRL_RST}, "ctrl reset");
    rd(`CAM_REG_ISTAT); chk32(rv, 32'h0, "istat reset");
    chk1(irq_o, 1'b0, "irq reset");
    rd(8'h3C); chk32(rv, 32'h0, "unmapped read");
    find(32'h5EED0031);
    rd(`CAM_REG_RES); chk32(rv, 32'h1F, "preloaded entry");
    $display("done: reset");
  endtask : t_reset

  // fill every entry with distinct words, then find each
  task t_encoded;
    for (int i = 0; i < 32; i++) put(i[4:0], 32'hA5000000 | i, 32'h0);
    for (int i = 0; i < 32; i++) begin
      find(32'hA5000000 | i);
      rd(`CAM_REG_RES); chk32(rv, i, "encoded index");
      rd(`CAM_REG_STAT); chk1(rv[2], 1'b1, "match flag");
    end
    $display("done: encoded");
  endtask : t_encoded

  // masked entries, two hits seen on the unencoded lines, then a miss
  task t_unencoded;
    put(5'h05, 32'h12345600, 32'h000000FF);
    put(5'h14, 32'h12340000, 32'h0000FFFF);
    wr(`CAM_REG_CTRL, 32'h6);
    find(32'h123456EF);
    rd(`CAM_REG_HITLO); chk32(rv, 32'h20, "low hit lines");
    rd(`CAM_REG_HITHI); chk32(rv, 32'h10, "high hit lines");
    find(32'h0BADF00D);
    rd(`CAM_REG_STAT); chk1(rv[2], 1'b0, "miss flag");
    rd(`CAM_REG_HITLO); chk32(rv, 32'h0, "miss low lines");
    rd(`CAM_REG_HITHI); chk32(rv, 32'h0, "miss high lines");
    wr(`CAM_REG_CTRL, 32'h7);
    $display("done: unencoded");
  endtask : t_unencoded

  // sticky events, mask and write-one-to-clear
  task t_irq;
    wr(`CAM_REG_ISTAT, 32'hFFFFFFFF);
    wr(`CAM_REG_IMASK, 32'h0);
    put(5'h07, 32'hA5000007, 32'h0);
    find(32'hA5000007);
    rd(`CAM_REG_ISTAT); chk32(rv, 32'h7, "events set");
    chk1(irq_o, 1'b0, "irq masked");
    wr(`CAM_REG_IMASK, 32'h2);
    chk1(irq_o, 1'b1, "irq raised");
    wr(`CAM_REG_ISTAT, 32'h2);
    rd(`CAM_REG_ISTAT); chk32(rv, 32'h5, "event cleared");
    chk1(irq_o, 1'b0, "irq dropped");
    $display("done: irq");
  endtask : t_irq

  // reset in mid-run reloads the configuration contents
  task t_rerun;
    rst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rd(`CAM_REG_CTRL); chk32(rv, {27'h0, `CAM_CTRL_RST}, "ctrl after reset");
    find(32'hA5000003);
    rd(`CAM_REG_STAT); chk1(rv[2], 1'b0, "written entry gone");
    find(32'h5EED0031);
    rd(`CAM_REG_RES); chk32(rv, 32'h1F, "preload back");
    $display("done: rerun");
  endtask : t_rerun

  // the tile's own clears wipe run-time writes and restore the preload
  task t_clear;
    put(5'h09, 32'hC1EA0009, 32'h0);
    find(32'hC1EA0009);
    rd(`CAM_REG_RES); chk32(rv, 32'h9, "written before clear");
    wr(`CAM_REG_CTRL, 32'h1F);
    wr(`CAM_REG_CTRL, 32'h07);
    find(32'hC1EA0009);
    rd(`CAM_REG_STAT); chk1(rv[2], 1'b0, "cleared entry gone");
    find(32'h5EED0031);
    rd(`CAM_REG_RES); chk32(rv, 32'h1F, "preload after clear");
    $display("done: clear");
  endtask : t_clear

  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end

  initial begin
    rst_i = 1'b1; cyc_i = 1'b0; stb_i = 1'b0; we_i = 1'b0;
    adr_i = 8'h0; sel_i = 4'h0; dat_i = 32'h0;
    mismatches = 0; checks_done = 0;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_reset();
    t_encoded();
    t_unencoded();
    t_irq();
    t_rerun();
    t_clear();
    complete_run();
  end
endmodule : testbench
